/* dv/debug_programmer_model.sv */
// External programmer on the single-pin debug port
`timescale 1ns/100ps

module debug_programmer_model (
    // Clock
    input wire logic core_clk_i,
    // Fuse values left by the programmer
    output nvm_prot_pkg::prot_cfg_t cfg_o,
    output logic lock_o,
    // Debug port requests
    output nvm_prot_pkg::dbg_req_t req_o
);
    initial begin
        cfg_o = '0;
        lock_o = 1'b0;
        req_o = '0;
    end

    // Takes effect only at the reset the caller applies next
    task automatic burn(input logic protect, input logic locked);
        cfg_o = protect ? nvm_prot_pkg::prot_cfg_t'({nvm_prot_pkg::PROTECTION_ACTIVE_KEY,
            nvm_prot_pkg::CFG_UNUSED_ZERO, nvm_prot_pkg::ACCESS_DISABLED_LEVEL}) : '0;
        lock_o = locked;
    endtask

    // Released lines show inverted values with erase cleared, not the last ones
    task automatic send(input logic wr, input logic er, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        req_o = '{valid: 1'b1, write: wr, erase: er, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1;
        req_o = '{valid: 1'b0, write: ~wr, erase: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

/* dv/nvm_access_protection_factory_info_row_chk.sv */
// Port-level checks for the access protection block
`timescale 1ns/100ps

module nvm_access_protection_factory_info_row_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Requests and status in
    input wire logic crc_ok_i,
    input wire nvm_prot_pkg::cpu_req_t cpu_req_i,
    input wire nvm_prot_pkg::dbg_req_t dbg_req_i,
    // Design outputs
    input wire nvm_prot_pkg::resp_t cpu_resp_o,
    input wire nvm_prot_pkg::resp_t dbg_resp_o,
    input wire nvm_prot_pkg::fwd_t fwd_o,
    input wire logic full_erase_command_o,
    input wire logic crc_status_o,
    input wire logic protect_active_o,
    input wire logic locked_o,
    input wire logic [15:0] stack_reset_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_CPU_ONE_ANSWER: assert property (cpu_req_i.valid |=> cpu_resp_o.ack ^ cpu_resp_o.err)
        else $error("CPU request not answered by exactly one of ack and err");
    AST_NO_SRAM_FETCH: assert property (
        cpu_req_i.valid && cpu_req_i.fetch && cpu_req_i.addr[15:11] == 5'h0f |=> cpu_resp_o.err && !fwd_o.valid)
        else $error("Fetch from SRAM was not refused");
    AST_INFO_ROW_RO: assert property (cpu_req_i.valid && cpu_req_i.write &&
        cpu_req_i.addr[15:5] == nvm_prot_pkg::INFO_ROW_BASE[15:5] |=> cpu_resp_o.err && !fwd_o.valid)
        else $error("Write to information row was not refused");
    AST_PROT_DBG_REFUSE: assert property (
        dbg_req_i.valid && protect_active_o |=> dbg_resp_o.err && !full_erase_command_o)
        else $error("Debug access granted under protection");
    AST_PROT_BOOT_ONLY: assert property (cpu_req_i.valid && cpu_req_i.write && cpu_req_i.addr[15] &&
        protect_active_o && !cpu_req_i.boot_exec |=> cpu_resp_o.err && !fwd_o.valid)
        else $error("Flash write outside boot code accepted under protection");
    AST_CRC_FOLLOWS: assert property ($past(rst_n_i) |-> crc_status_o == $past(crc_ok_i))
        else $error("CRC status does not follow its input");
    AST_STACK_TOP: assert property (stack_reset_o == nvm_prot_pkg::SRAM_END)
        else $error("Stack reset value is not the top of SRAM");
    AST_LOCKED_USER_READ: assert property (dbg_req_i.valid && !dbg_req_i.write && !dbg_req_i.erase &&
        locked_o && dbg_req_i.addr[15:6] == nvm_prot_pkg::USER_ROW_BASE[15:6]
        |=> dbg_resp_o.err && dbg_resp_o.rdata == 8'h00)
        else $error("Debug read of user row allowed while locked");
    AST_ERASE_PULSE: assert property (
        dbg_req_i.valid && dbg_req_i.erase && !protect_active_o |=> full_erase_command_o && dbg_resp_o.ack)
        else $error("Full erase not issued with its ack");
    AST_SRAM_FORWARD: assert property (cpu_req_i.valid && cpu_req_i.write && !cpu_req_i.fetch &&
        cpu_req_i.addr[15:11] == 5'h0f |=> fwd_o.valid && fwd_o.region == nvm_prot_pkg::REGION_SRAM
        && fwd_o.addr == $past(cpu_req_i.addr))
        else $error("SRAM write not forwarded to SRAM");
    AST_PROT_NEEDS_LOCK: assert property (protect_active_o |-> locked_o)
        else $error("Protection active on an unlocked device");
endmodule

bind nvm_access_protection_factory_info_row nvm_access_protection_factory_info_row_chk nvm_access_protection_factory_info_row_chk_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .crc_ok_i(crc_ok_i), .cpu_req_i(cpu_req_i),
    .dbg_req_i(dbg_req_i), .cpu_resp_o(cpu_resp_o), .dbg_resp_o(dbg_resp_o), .fwd_o(fwd_o),
    .full_erase_command_o(full_erase_command_o), .crc_status_o(crc_status_o),
    .protect_active_o(protect_active_o), .locked_o(locked_o), .stack_reset_o(stack_reset_o));

/* dv/nvm_access_protection_factory_info_row_tb.sv */
// Self-checking bench for the access protection block
`timescale 1ns/100ps

module nvm_access_protection_factory_info_row_tb;
    localparam logic [23:0] ID = 24'h5a6b7c; // Arbitrary value
    localparam logic [15:0] GAIN = 16'h8123;
    localparam logic [15:0] OFS = 16'h7f45;
    localparam logic [127:0] SER = 128'h102132435465768798a9bacbdcedfe0f; // Arbitrary value
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic crc_ok_i = 1'b0;
    logic ok;
    logic lock;
    logic full_erase_command_o, crc_status_o, protect_active_o, locked_o;
    logic [15:0] stack_reset_o;
    logic [15:0] win [6] = '{16'h7800, 16'h7fff, 16'h77ff, 16'h1400, 16'h15ff, 16'h1600};
    nvm_prot_pkg::cpu_req_t cpu_req_i = '0;
    nvm_prot_pkg::prot_cfg_t cfg;
    nvm_prot_pkg::dbg_req_t dbg_req;
    nvm_prot_pkg::resp_t cpu_resp_o, dbg_resp_o;
    nvm_prot_pkg::fwd_t fwd_o;
    nvm_prot_pkg::region_t rg;
    int n_mismatch = 0;
    int checks_done = 0;

    always #5 core_clk_i = ~core_clk_i;

    nvm_access_protection_factory_info_row #(.PART_IDENTIFIER(ID), .TEMP_GAIN_CALIBRATION(GAIN),
        .TEMP_OFFSET_CALIBRATION(OFS), .UNIT_SERIAL(SER)) nvm_access_protection_factory_info_row_inst (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .protection_config_fuse_i(cfg), .lock_key_locked_i(lock),
        .crc_ok_i(crc_ok_i), .cpu_req_i(cpu_req_i), .cpu_resp_o(cpu_resp_o), .dbg_req_i(dbg_req),
        .dbg_resp_o(dbg_resp_o), .fwd_o(fwd_o), .full_erase_command_o(full_erase_command_o),
        .crc_status_o(crc_status_o), .protect_active_o(protect_active_o), .locked_o(locked_o),
        .stack_reset_o(stack_reset_o));

    debug_programmer_model debug_programmer_model_inst (.core_clk_i(core_clk_i), .cfg_o(cfg), .lock_o(lock),
        .req_o(dbg_req));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rsp(input nvm_prot_pkg::resp_t r, input logic a, input logic [7:0] d);
        chk(16'(r), {6'h00, a, ~a, d});
    endtask

    task automatic cpu(input logic wr, input logic fe, input logic bx, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        cpu_req_i = '{valid: 1'b1, write: wr, fetch: fe, boot_exec: bx, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1;
        cpu_req_i = '{valid: 1'b0, write: ~wr, fetch: ~fe, boot_exec: ~bx, addr: ~a, wdata: ~d};
    endtask

    task automatic dbg(input logic wr, input logic er, input logic [15:0] a, input logic [7:0] d);
        debug_programmer_model_inst.send(wr, er, a, d);
    endtask

    // Fuses are captured at the first edge after reset
    task automatic boot(input logic p, input logic l);
        debug_programmer_model_inst.burn(p, l);
        rst_n_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    function automatic logic [7:0] info_byte(input int o);
        logic [255:0] row;
        row = {SER, 64'h0, OFS, GAIN, 8'h00, ID};
        return row[8*o +: 8];
    endfunction

    task automatic final_report;
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Far beyond the expected run length
    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end

    initial begin
        boot(1'b0, 1'b0);
        chk(stack_reset_o, 16'h7fff);
        for (int o = 0; o < 32; o++) begin
            cpu(1'b0, 1'b0, 1'b0, nvm_prot_pkg::INFO_ROW_BASE + 16'(o), 8'h00);
            rsp(cpu_resp_o, 1'b1, info_byte(o));
        end
        cpu(1'b1, 1'b0, 1'b0, 16'h1104, 8'hff);
        rsp(cpu_resp_o, 1'b0, 8'h00);
        cpu(1'b0, 1'b0, 1'b0, 16'h1104, 8'h00);
        rsp(cpu_resp_o, 1'b1, GAIN[7:0]);
        for (int i = 0; i < 6; i++) begin
            cpu(1'b1, 1'b0, 1'b0, win[i], 8'ha5);
            ok = win[i][15:11] == 5'h0f || win[i][15:9] == 7'h0a;
            rg = win[i][14] ? nvm_prot_pkg::REGION_SRAM : nvm_prot_pkg::REGION_EEPROM;
            rsp(cpu_resp_o, ok, 8'h00);
            chk(16'(fwd_o.valid), 16'(ok));
            if (ok)
                chk(16'(fwd_o.region), 16'(rg));
        end
        cpu(1'b0, 1'b1, 1'b0, 16'h7fff, 8'h00);
        rsp(cpu_resp_o, 1'b0, 8'h00);
        cpu(1'b0, 1'b1, 1'b0, 16'h8000, 8'h00);
        rsp(cpu_resp_o, 1'b1, 8'h00);
        cpu(1'b1, 1'b0, 1'b0, 16'h1205, 8'h5a);
        rsp(cpu_resp_o, 1'b1, 8'h00);
        dbg(1'b0, 1'b1, 16'h0000, 8'h00);
        chk(16'({dbg_resp_o.ack, full_erase_command_o}), 16'h0003);
        cpu(1'b0, 1'b0, 1'b0, 16'h1205, 8'h00);
        rsp(cpu_resp_o, 1'b1, 8'h5a);
        // Debug write forwarded to EEPROM while unlocked
        dbg(1'b1, 1'b0, 16'h1401, 8'h66);
        rsp(dbg_resp_o, 1'b1, 8'h00);
        chk(16'({fwd_o.valid, fwd_o.write, fwd_o.from_dbg}), 16'h0007);
        chk(16'(fwd_o.region), 16'(nvm_prot_pkg::REGION_EEPROM));
        chk(fwd_o.addr, 16'h1401);
        chk(16'(fwd_o.wdata), 16'h0066);
        // CPU and debug forward in one cycle: CPU wins, debug gets err
        fork
            cpu(1'b1, 1'b0, 1'b0, 16'h7800, 8'h01);
            dbg(1'b0, 1'b0, 16'h1401, 8'h00);
        join
        rsp(dbg_resp_o, 1'b0, 8'h00);
        chk(16'({fwd_o.valid, fwd_o.from_dbg}), 16'h0002);
        boot(1'b0, 1'b1);
        chk(16'({locked_o, protect_active_o}), 16'h0002);
        dbg(1'b1, 1'b0, 16'h1210, 8'h3c);
        rsp(dbg_resp_o, 1'b1, 8'h00);
        dbg(1'b0, 1'b0, 16'h1210, 8'h00);
        rsp(dbg_resp_o, 1'b0, 8'h00);
        cpu(1'b0, 1'b0, 1'b0, 16'h1210, 8'h00);
        rsp(cpu_resp_o, 1'b1, 8'h3c);
        dbg(1'b0, 1'b0, 16'h1102, 8'h00);
        rsp(dbg_resp_o, 1'b1, ID[23:16]);
        dbg(1'b1, 1'b0, 16'h1400, 8'h11);
        rsp(dbg_resp_o, 1'b0, 8'h00);
        boot(1'b1, 1'b1);
        chk(16'(protect_active_o), 16'h0001);
        dbg(1'b0, 1'b0, 16'h1100, 8'h00);
        rsp(dbg_resp_o, 1'b0, 8'h00);
        dbg(1'b1, 1'b0, 16'h1210, 8'h77);
        rsp(dbg_resp_o, 1'b0, 8'h00);
        dbg(1'b0, 1'b1, 16'h0000, 8'h00);
        chk(16'({dbg_resp_o.err, full_erase_command_o}), 16'h0002);
        cpu(1'b0, 1'b0, 1'b0, 16'h1210, 8'h00);
        rsp(cpu_resp_o, 1'b1, 8'h3c);
        cpu(1'b1, 1'b0, 1'b0, 16'h8000, 8'h12);
        rsp(cpu_resp_o, 1'b0, 8'h00);
        cpu(1'b1, 1'b0, 1'b1, 16'h8000, 8'h12);
        chk(16'({fwd_o.valid, fwd_o.region}), 16'({1'b1, nvm_prot_pkg::REGION_FLASH}));
        crc_ok_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        chk(16'(crc_status_o), 16'h0001);
        final_report;
    end
endmodule

/* verilog/nvm_access_protection_factory_info_row.sv */
// Access protection, memory windows, factory information row and end-user row
`timescale 1ns/100ps

module nvm_access_protection_factory_info_row #(
    parameter logic [23:0] PART_IDENTIFIER = 24'h00_00_01, // Arbitrary value
    parameter logic [15:0] TEMP_GAIN_CALIBRATION = 16'h0000,
    parameter logic [15:0] TEMP_OFFSET_CALIBRATION = 16'h0000,
    parameter logic [127:0] UNIT_SERIAL = 128'h0, // Arbitrary value
    parameter int USER_ROW_BYTES = 64
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Fuse and status inputs
    input wire nvm_prot_pkg::prot_cfg_t protection_config_fuse_i,
    input wire logic lock_key_locked_i,
    input wire logic crc_ok_i,
    // CPU side
    input wire nvm_prot_pkg::cpu_req_t cpu_req_i,
    output nvm_prot_pkg::resp_t cpu_resp_o,
    // Single-pin debug port side
    input wire nvm_prot_pkg::dbg_req_t dbg_req_i,
    output nvm_prot_pkg::resp_t dbg_resp_o,
    // Memory controller side
    output nvm_prot_pkg::fwd_t fwd_o,
    output logic full_erase_command_o,
    // Status
    output logic crc_status_o,
    output logic protect_active_o,
    output logic locked_o,
    output logic [15:0] stack_reset_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (USER_ROW_BYTES != 64) begin : g_bad_user_row
        $error("end-user row must be 64 bytes");
    end

    // ************************************************************
    // Decoding functions
    // ************************************************************
    function automatic nvm_prot_pkg::region_t region_of(input logic [15:0] addr);
        nvm_prot_pkg::region_t r;
        r = nvm_prot_pkg::REGION_NONE;
        if (addr >= nvm_prot_pkg::FLASH_START) begin
            r = nvm_prot_pkg::REGION_FLASH;
        end else if (addr >= nvm_prot_pkg::SRAM_START && addr <= nvm_prot_pkg::SRAM_END) begin
            r = nvm_prot_pkg::REGION_SRAM;
        end else if (addr >= nvm_prot_pkg::EEPROM_START &&
                     addr < nvm_prot_pkg::EEPROM_START + nvm_prot_pkg::EEPROM_SIZE) begin
            r = nvm_prot_pkg::REGION_EEPROM;
        end else if (addr >= nvm_prot_pkg::INFO_ROW_BASE &&
                     addr < nvm_prot_pkg::INFO_ROW_BASE + nvm_prot_pkg::INFO_ROW_SIZE) begin
            r = nvm_prot_pkg::REGION_INFO;
        end else if (addr >= nvm_prot_pkg::USER_ROW_BASE &&
                     addr < nvm_prot_pkg::USER_ROW_BASE + nvm_prot_pkg::USER_ROW_SIZE) begin
            r = nvm_prot_pkg::REGION_USER;
        end
        return r;
    endfunction

    function automatic logic [7:0] info_byte(input logic [4:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        if (ofs <= nvm_prot_pkg::ID_OFS_LAST) begin
            b = PART_IDENTIFIER[8 * ofs[1:0] +: 8];
        end else if (ofs == nvm_prot_pkg::GAIN_OFS || ofs == nvm_prot_pkg::GAIN_OFS + 5'h01) begin
            b = TEMP_GAIN_CALIBRATION[8 * ofs[0] +: 8];
        end else if (ofs == nvm_prot_pkg::OFFSET_OFS || ofs == nvm_prot_pkg::OFFSET_OFS + 5'h01) begin
            b = TEMP_OFFSET_CALIBRATION[8 * ofs[0] +: 8];
        end else if (ofs >= nvm_prot_pkg::SERIAL_OFS_FIRST) begin
            b = UNIT_SERIAL[8 * ofs[3:0] +: 8];
        end
        return b;
    endfunction

    // ************************************************************
    // Protection state, taken once after reset release; CRC status follows every cycle
    // ************************************************************
    logic fuses_taken;
    logic prot_q;
    logic lock_q;
    logic crc_q;
    wire logic cfg_requests_prot;

    assign cfg_requests_prot = protection_config_fuse_i.key == nvm_prot_pkg::PROTECTION_ACTIVE_KEY &&
                               protection_config_fuse_i.unused == nvm_prot_pkg::CFG_UNUSED_ZERO &&
                               protection_config_fuse_i.level == nvm_prot_pkg::ACCESS_DISABLED_LEVEL;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fuses_taken <= 1'b0;
            prot_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (!fuses_taken) begin
            fuses_taken <= 1'b1;
            prot_q <= cfg_requests_prot & lock_key_locked_i;
            lock_q <= lock_key_locked_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc_q <= 1'b0;
        end else begin
            crc_q <= crc_ok_i;
        end
    end

    // ************************************************************
    // End-user row storage
    // ************************************************************
    logic [7:0] user_row [USER_ROW_BYTES];

    // ************************************************************
    // CPU access decode
    // ************************************************************
    nvm_prot_pkg::region_t cpu_region;
    wire logic cpu_rd;
    wire logic cpu_wr;
    wire logic cpu_fetch_sram;
    wire logic cpu_flash_wr_bad;
    wire logic cpu_info_wr;
    wire logic cpu_local;
    wire logic cpu_user_wr;
    wire logic dbg_user_wr;
    wire logic cpu_deny;
    wire logic cpu_fwd;
    wire logic [7:0] cpu_local_data;

    assign cpu_region = region_of(cpu_req_i.addr);
    assign cpu_rd = cpu_req_i.valid & ~cpu_req_i.write;
    assign cpu_wr = cpu_req_i.valid & cpu_req_i.write;
    assign cpu_fetch_sram = cpu_rd & cpu_req_i.fetch & (cpu_region != nvm_prot_pkg::REGION_FLASH);
    assign cpu_flash_wr_bad = cpu_wr & (cpu_region == nvm_prot_pkg::REGION_FLASH) &
                              prot_q & ~cpu_req_i.boot_exec;
    assign cpu_info_wr = cpu_wr & (cpu_region == nvm_prot_pkg::REGION_INFO);
    assign cpu_local = cpu_region == nvm_prot_pkg::REGION_INFO || cpu_region == nvm_prot_pkg::REGION_USER;
    assign cpu_user_wr = cpu_wr & (cpu_region == nvm_prot_pkg::REGION_USER) & ~dbg_user_wr;
    assign cpu_deny = cpu_fetch_sram | cpu_flash_wr_bad | cpu_info_wr |
                      (cpu_req_i.valid & cpu_region == nvm_prot_pkg::REGION_NONE) |
                      (cpu_wr & cpu_region == nvm_prot_pkg::REGION_USER & dbg_user_wr);
    assign cpu_fwd = cpu_req_i.valid & ~cpu_deny & ~cpu_local;
    assign cpu_local_data = (cpu_region == nvm_prot_pkg::REGION_INFO) ? info_byte(cpu_req_i.addr[4:0]) :
                            user_row[cpu_req_i.addr[5:0]];

    // ************************************************************
    // Debug port access decode
    // ************************************************************
    nvm_prot_pkg::region_t dbg_region;
    wire logic dbg_rd;
    wire logic dbg_wr;
    wire logic dbg_erase;
    wire logic dbg_is_id;
    wire logic dbg_rd_bad;
    wire logic dbg_wr_bad;
    wire logic dbg_local;
    wire logic dbg_want_fwd;
    wire logic dbg_busy;
    wire logic dbg_deny;
    wire logic dbg_fwd;
    wire logic [7:0] dbg_local_data;

    assign dbg_region = region_of(dbg_req_i.addr);
    assign dbg_erase = dbg_req_i.valid & dbg_req_i.erase;
    assign dbg_rd = dbg_req_i.valid & ~dbg_req_i.erase & ~dbg_req_i.write;
    assign dbg_wr = dbg_req_i.valid & ~dbg_req_i.erase & dbg_req_i.write;
    assign dbg_is_id = dbg_region == nvm_prot_pkg::REGION_INFO &&
                       dbg_req_i.addr[4:0] <= nvm_prot_pkg::ID_OFS_LAST;
    // Locked: reads only the part identifier, writes only the end-user row; protected: nothing at all
    assign dbg_rd_bad = dbg_rd & (prot_q | (lock_q & ~dbg_is_id) |
                        dbg_region == nvm_prot_pkg::REGION_NONE);
    assign dbg_wr_bad = dbg_wr & (prot_q | dbg_region == nvm_prot_pkg::REGION_INFO |
                        dbg_region == nvm_prot_pkg::REGION_NONE |
                        (lock_q & dbg_region != nvm_prot_pkg::REGION_USER));
    assign dbg_user_wr = dbg_wr & ~dbg_wr_bad & (dbg_region == nvm_prot_pkg::REGION_USER);
    assign dbg_local = dbg_region == nvm_prot_pkg::REGION_INFO || dbg_region == nvm_prot_pkg::REGION_USER;
    assign dbg_want_fwd = (dbg_rd | dbg_wr) & ~dbg_rd_bad & ~dbg_wr_bad & ~dbg_local;
    assign dbg_busy = dbg_want_fwd & cpu_fwd;
    assign dbg_deny = dbg_rd_bad | dbg_wr_bad | dbg_busy | (dbg_erase & prot_q);
    assign dbg_fwd = dbg_want_fwd & ~cpu_fwd;
    assign dbg_local_data = (dbg_region == nvm_prot_pkg::REGION_INFO) ? info_byte(dbg_req_i.addr[4:0]) :
                            user_row[dbg_req_i.addr[5:0]];

    // ************************************************************
    // End-user row writes; full erase leaves it alone
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (dbg_user_wr) begin
            user_row[dbg_req_i.addr[5:0]] <= dbg_req_i.wdata;
        end else if (cpu_user_wr) begin
            user_row[cpu_req_i.addr[5:0]] <= cpu_req_i.wdata;
        end
    end

    // ************************************************************
    // Answers, forwarding and erase
    // ************************************************************
    nvm_prot_pkg::resp_t next_cpu_resp;
    nvm_prot_pkg::resp_t next_dbg_resp;
    nvm_prot_pkg::fwd_t next_fwd;

    assign next_cpu_resp = '{ack: cpu_req_i.valid & ~cpu_deny, err: cpu_deny,
                             rdata: (cpu_rd & ~cpu_deny & cpu_local) ? cpu_local_data : 8'h00};
    assign next_dbg_resp = '{ack: dbg_req_i.valid & ~dbg_deny, err: dbg_deny,
                             rdata: (dbg_rd & ~dbg_deny & dbg_local) ? dbg_local_data : 8'h00};
    assign next_fwd = cpu_fwd ?
        nvm_prot_pkg::fwd_t'{valid: 1'b1, write: cpu_req_i.write, from_dbg: 1'b0, region: cpu_region,
          addr: cpu_req_i.addr, wdata: cpu_req_i.wdata} :
        dbg_fwd ?
        nvm_prot_pkg::fwd_t'{valid: 1'b1, write: dbg_req_i.write, from_dbg: 1'b1, region: dbg_region,
          addr: dbg_req_i.addr, wdata: dbg_req_i.wdata} :
        nvm_prot_pkg::FWD_IDLE;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_resp_o <= nvm_prot_pkg::RESP_IDLE;
            dbg_resp_o <= nvm_prot_pkg::RESP_IDLE;
            fwd_o <= nvm_prot_pkg::FWD_IDLE;
            full_erase_command_o <= 1'b0;
        end else begin
            cpu_resp_o <= next_cpu_resp;
            dbg_resp_o <= next_dbg_resp;
            fwd_o <= next_fwd;
            full_erase_command_o <= dbg_erase & ~prot_q;
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    assign crc_status_o = crc_q;
    assign protect_active_o = prot_q;
    assign locked_o = lock_q;
    assign stack_reset_o = nvm_prot_pkg::SRAM_END;

endmodule

/* verilog/nvm_prot_pkg.sv */
// Shared constants and types for the nonvolatile memory access protection block
package nvm_prot_pkg;

    // ************************************************************
    // Data space windows
    // ************************************************************
    localparam logic [15:0] SRAM_START = 16'h7800;
    localparam logic [15:0] SRAM_END = 16'h7fff;
    localparam logic [15:0] EEPROM_START = 16'h1400;
    localparam logic [15:0] EEPROM_SIZE = 16'h0200;
    localparam logic [15:0] FLASH_START = 16'h8000;
    localparam logic [15:0] INFO_ROW_BASE = 16'h1100;
    localparam logic [15:0] INFO_ROW_SIZE = 16'h0020;
    localparam logic [15:0] USER_ROW_BASE = 16'h1200;
    localparam logic [15:0] USER_ROW_SIZE = 16'h0040;

    // ************************************************************
    // Factory information row offsets
    // ************************************************************
    localparam logic [4:0] ID_OFS_FIRST = 5'h00;
    localparam logic [4:0] ID_OFS_LAST = 5'h02;
    localparam logic [4:0] GAIN_OFS = 5'h04;
    localparam logic [4:0] OFFSET_OFS = 5'h06;
    localparam logic [4:0] SERIAL_OFS_FIRST = 5'h10;
    localparam logic [4:0] SERIAL_OFS_LAST = 5'h1f;

    // ************************************************************
    // Protection configuration fuse
    // ************************************************************
    localparam logic [11:0] PROTECTION_ACTIVE_KEY = 12'hb45;
    localparam logic [1:0] ACCESS_DISABLED_LEVEL = 2'h2;
    localparam logic [1:0] CFG_UNUSED_ZERO = 2'h0;

    typedef struct packed {
        logic [11:0] key;
        logic [1:0] unused;
        logic [1:0] level;
    } prot_cfg_t;

    // ************************************************************
    // Regions, requests and answers
    // ************************************************************
    typedef enum logic [2:0] {
        REGION_NONE = 3'h0,
        REGION_SRAM = 3'h1,
        REGION_EEPROM = 3'h3,
        REGION_FLASH = 3'h2,
        REGION_INFO = 3'h6,
        REGION_USER = 3'h7
    } region_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic boot_exec;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic erase;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dbg_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
    } resp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic from_dbg;
        region_t region;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fwd_t;

    localparam resp_t RESP_IDLE = '{ack: 1'b0, err: 1'b0, rdata: 8'h00};
    localparam fwd_t FWD_IDLE = '{valid: 1'b0, write: 1'b0, from_dbg: 1'b0, region: REGION_NONE,
                                  addr: 16'h0000, wdata: 8'h00};

endpackage
